// *** sleep_wakeup_and_watchdog.sv ***
// Power mode control, sleep and wake-up sequencing, and the watchdog.
// Assumes CPU strobes and config come from sys_clk logic; pins and slow oscillators are asynchronous.
//
// What this block does
// - Clock select picks Normal or Slow mode
// - Halt stops oscillator and program, keeps state
// - Sleep clears watchdog; stops only on sysclk
// - Halt sets power-down, clears expired; ports hold
// - Wake on reset, port edge, interrupt, overflow
// - Reset wake resets all; watchdog wake PC/SP
// - Power-down flag: cleared power-up/clear, set halt
// - Enabled port falling edge wakes, resumes next
// - Disabled or stack-full interrupt resumes, stays pending
// - Interrupt already pending at halt never wakes
// - Every wake-up waits 2 or 1024 clocks
// - Reset wake adds reset delay before start-up
// - Overflow resets; disabled watchdog makes clears no-ops
// - Option forces watchdog on; else field 1010 off
// - Field resets to off code; 0101 suggested
// - Watchdog clock: crystal, sysclk/4 or internal RC
// - Three period bits; all high gives longest
// - Awake time-out resets and sets expired flag
// - Counter cleared by reset pin, clears, halt
// - Option picks single clear or clear pair
// - Pair mode: repeats ignored, alternation clears
// - Clock select works only in HIGH_SPEED_INTERNAL_RC plus LOW_SPEED_CRYSTAL_OSC
`include "sleep_wakeup_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sleep_wakeup_and_watchdog #(
  // Reset delay in cycles, shortened in simulation
  parameter int unsigned RESET_DELAY_CYCLES = `RESET_DELAY_US * `CLK_FREQ_MHZ
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire sleep_wakeup_pkg::cpu_cmd_s cpu_cmd,
  input wire sleep_wakeup_pkg::cfg_s cfg,
  input wire logic [3:0] irq_request,
  input wire logic [3:0] irq_enable,
  input wire logic stack_full,
  input wire logic [7:0] port_a_pins,
  input wire logic external_clear_pin_n,
  input wire logic lxt_clk,
  input wire logic low_speed_internal_rc_clk,
  output logic cpu_run,
  output logic high_speed_internal_rc_run,
  output logic slow_mode,
  output logic port_hold,
  output logic sys_reset,
  output logic pc_sp_reset,
  output logic irq_service,
  output logic resume_next
);

  // ****************************************
  // State and helpers
  // ****************************************
  sleep_wakeup_pkg::state_s q; // Registered state
  sleep_wakeup_pkg::state_s d; // Next state

  // Reset delay end, cut to the delay counter width
  localparam logic [23:0] RST_LAST = 24'(RESET_DELAY_CYCLES - 1);

  // Counter value at which the selected period ends
  function automatic logic [14:0] wdt_limit(input logic [2:0] sel);
    wdt_limit = 15'h7fff >> (3'h7 - sel);
  endfunction : wdt_limit

  logic wdt_on; // Watchdog function enabled
  logic wdt_tick; // One count of the watchdog clock
  logic wdt_timeout; // Counter reaches its period
  logic wdt_clear_sw; // Software clear completes
  logic [7:0] pa_fall; // Enabled port falling edges
  logic [3:0] irq_new; // Requests not pending at halt
  logic crystal; // Start-up uses crystal timing
  logic [23:0] sst_last; // Last start-up count
  logic bus_req; // New bus request this cycle

  // ****************************************
  // Combinational next state
  // ****************************************
  // All decisions in one process; the struct keeps state in one register.
  always_comb begin
    d = q;
    d.sys_reset = 1'b0;
    d.pc_sp_reset = 1'b0;
    d.irq_service = 1'b0;
    d.resume_next = 1'b0;

    // Two-stage synchronisers for asynchronous pins and slow clocks.
    // Only the second stage feeds logic; the first may be metastable.
    // The extra copy after the second stage gives the edge detectors
    // their previous value without reading the first stage.
    d.pa_s1 = port_a_pins;
    d.pa_s2 = q.pa_s1;
    d.pa_prev = q.pa_s2;
    d.clr_s1 = external_clear_pin_n;
    d.clr_s2 = q.clr_s1;
    d.lxt_s1 = lxt_clk;
    d.lxt_s2 = q.lxt_s1;
    d.lxt_prev = q.lxt_s2;
    d.low_speed_internal_rc_s1 = low_speed_internal_rc_clk;
    d.low_speed_internal_rc_s2 = q.low_speed_internal_rc_s1;
    d.low_speed_internal_rc_prev = q.low_speed_internal_rc_s2;

    // Option forces on; otherwise only the off code disables
    wdt_on = cfg.wdt_force_on | (q.wdt_field != `WDT_FIELD_OFF);

    // Divided system clock halts with the system clock in sleep
    d.div = (q.st == sleep_wakeup_pkg::st_sleep) ? q.div : q.div + 2'h1;
    case (cfg.wdt_src)
      sleep_wakeup_pkg::wsrc_lxt: wdt_tick = q.lxt_s2 & ~q.lxt_prev;
      sleep_wakeup_pkg::wsrc_sys_div4: wdt_tick = (q.div == 2'h3) & (q.st != sleep_wakeup_pkg::st_sleep);
      default: wdt_tick = q.low_speed_internal_rc_s2 & ~q.low_speed_internal_rc_prev;
    endcase
    wdt_timeout = wdt_on & wdt_tick & (q.wdt_cnt == wdt_limit(q.ws));

    // Falling edges on enabled port pins
    pa_fall = q.pa_prev & ~q.pa_s2 & q.pa_wake_en;
    // Interrupts pending at halt are masked from waking
    irq_new = irq_request & ~q.irq_old;

    // Start-up length by oscillator kind
    crystal = (cfg.osc_type == sleep_wakeup_pkg::osc_hxt) | q.slow_mode;
    sst_last = ((~crystal & cfg.sst_short) ? `SST_SHORT_CYCLES : `SST_LONG_CYCLES) - 24'h1;

    // Software clear; all clears are no-ops while the watchdog is off
    wdt_clear_sw = 1'b0;
    if (wdt_on && q.st == sleep_wakeup_pkg::st_run) begin
      if (!cfg.clear_pair_mode) begin
        wdt_clear_sw = cpu_cmd.clear_insn;
      end else if (cpu_cmd.clear_first) begin
        // Repeat of the same half only re-arms it
        wdt_clear_sw = q.half_second;
        d.half_first = ~q.half_second;
        d.half_second = 1'b0;
      end else if (cpu_cmd.clear_second) begin
        wdt_clear_sw = q.half_first;
        d.half_second = ~q.half_first;
        d.half_first = 1'b0;
      end
    end
    if (wdt_clear_sw) begin
      d.power_down_flag = 1'b0;
    end

    // Watchdog counter
    if (!wdt_on || wdt_clear_sw || wdt_timeout) begin
      d.wdt_cnt = 15'h0000;
    end else if (wdt_tick) begin
      d.wdt_cnt = q.wdt_cnt + 15'h0001;
    end

    // ****************************************
    // Mode sequencing
    // ****************************************
    case (q.st)
      sleep_wakeup_pkg::st_run: begin
        if (wdt_timeout) begin
          // Awake time-out acts as a reset pin reset plus expired flag
          d.to = 1'b1;
          d.src = sleep_wakeup_pkg::wake_reset;
          d.st = sleep_wakeup_pkg::st_rst_delay;
          d.dly = 24'h000000;
          d.cpu_run = 1'b0;
        end else if (cpu_cmd.sleep_insn) begin
          // Halt: program and fast oscillator stop, state kept
          d.st = sleep_wakeup_pkg::st_sleep;
          d.cpu_run = 1'b0;
          d.high_speed_internal_rc_run = 1'b0;
          d.port_hold = 1'b1;
          d.power_down_flag = 1'b1;
          d.to = 1'b0;
          d.wdt_cnt = 15'h0000;
          d.half_first = 1'b0;
          d.half_second = 1'b0;
          d.irq_old = irq_request;
        end
      end
      sleep_wakeup_pkg::st_sleep: begin
        // Any wake source starts the start-up count
        if (wdt_timeout || (pa_fall != 8'h00) || (irq_new != 4'h0)) begin
          d.st = sleep_wakeup_pkg::st_startup;
          d.dly = 24'h000000;
          d.high_speed_internal_rc_run = ~q.slow_mode;
          if (wdt_timeout) begin
            d.to = 1'b1;
            d.src = sleep_wakeup_pkg::wake_wdt_sleep;
          end else if (pa_fall != 8'h00) begin
            d.src = sleep_wakeup_pkg::wake_port;
          end else begin
            d.src = sleep_wakeup_pkg::wake_irq;
          end
        end
      end
      sleep_wakeup_pkg::st_rst_delay: begin
        // Reset delay runs once the reset line is high again
        if (q.dly == RST_LAST) begin
          d.st = sleep_wakeup_pkg::st_startup;
          d.dly = 24'h000000;
        end else begin
          d.dly = q.dly + 24'h000001;
        end
      end
      default: begin
        // Start-up count, then the action that the wake source calls for
        if (q.dly == sst_last) begin
          d.st = sleep_wakeup_pkg::st_run;
          d.cpu_run = 1'b1;
          d.port_hold = 1'b0;
          case (q.src)
            sleep_wakeup_pkg::wake_reset: d.sys_reset = 1'b1;
            sleep_wakeup_pkg::wake_wdt_sleep: d.pc_sp_reset = 1'b1;
            sleep_wakeup_pkg::wake_irq: begin
              // Serviced only if a waking request is enabled and stack has room
              if (((irq_new & irq_enable) != 4'h0) && !stack_full) begin
                d.irq_service = 1'b1;
              end else begin
                d.resume_next = 1'b1;
              end
            end
            default: d.resume_next = 1'b1;
          endcase
        end else begin
          d.dly = q.dly + 24'h000001;
        end
      end
    endcase

    // Low reset pin overrides everything; flags stay as they were
    if (!q.clr_s2) begin
      d.st = sleep_wakeup_pkg::st_rst_delay;
      d.src = sleep_wakeup_pkg::wake_reset;
      d.dly = 24'h000000;
      d.wdt_cnt = 15'h0000;
      d.cpu_run = 1'b0;
      d.high_speed_internal_rc_run = 1'b1;
      d.port_hold = 1'b0;
      d.half_first = 1'b0;
      d.half_second = 1'b0;
    end

    // Slow mode only where the fast RC pairs with the crystal
    d.slow_mode = q.clk_sel & (cfg.osc_type == sleep_wakeup_pkg::osc_high_speed_internal_rc_lxt);
    // Keyed on the next state, not the present one: a halt taken in
    // this cycle must not switch the fast oscillator back on here,
    // or it would keep running through the whole of sleep.
    if (d.st == sleep_wakeup_pkg::st_run) begin
      d.high_speed_internal_rc_run = ~d.slow_mode;
    end

    // ****************************************
    // Wishbone slave
    // ****************************************
    // Answer one cycle after the request; ack drops the next cycle
    bus_req = cyc_i & stb_i & ~q.ack;
    d.ack = bus_req;
    d.rdata = 32'h00000000;
    if (bus_req && we_i && sel_i[0]) begin
      if (adr_i == `OFS_SYSTEM_CONTROL_A) begin
        d.clk_sel = dat_i[`BIT_CLOCK_SPEED_SELECT];
        d.lxt_lp = dat_i[`BIT_CRYSTAL_LOW_POWER];
      end else if (adr_i == `OFS_SYSTEM_CONTROL_B) begin
        d.wdt_field = dat_i[3:0];
      end else if (adr_i == `OFS_WDT_PERIOD_SEL) begin
        d.ws = dat_i[2:0];
      end else if (adr_i == `OFS_PORT_A_WAKE_EN) begin
        d.pa_wake_en = dat_i[7:0];
      end
    end else if (bus_req && !we_i) begin
      if (adr_i == `OFS_SYSTEM_CONTROL_A) begin
        d.rdata[`BIT_CLOCK_SPEED_SELECT] = q.clk_sel;
        d.rdata[`BIT_CRYSTAL_LOW_POWER] = q.lxt_lp;
      end else if (adr_i == `OFS_SYSTEM_CONTROL_B) begin
        d.rdata[3:0] = q.wdt_field;
      end else if (adr_i == `OFS_WDT_PERIOD_SEL) begin
        d.rdata[2:0] = q.ws;
      end else if (adr_i == `OFS_STATUS) begin
        d.rdata[`BIT_POWER_DOWN_FLAG] = q.power_down_flag;
        d.rdata[`BIT_WDT_EXPIRED_FLAG] = q.to;
        d.rdata[`BIT_SLEEPING] = (q.st == sleep_wakeup_pkg::st_sleep);
        d.rdata[`BIT_WDT_RUNNING] = wdt_on;
        d.rdata[`BIT_SLOW_MODE] = q.slow_mode;
      end else if (adr_i == `OFS_PORT_A_WAKE_EN) begin
        d.rdata[7:0] = q.pa_wake_en;
      end
      // Unmapped addresses read zero
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Synchronous power-up reset; flags and fields take their power-up values.
  // Port and reset-pin synchronisers start at the idle high level of their pins, so that
  // leaving reset never shows a false falling edge or a reset-pin pulse.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '0;
      q.st <= sleep_wakeup_pkg::st_startup;
      q.src <= sleep_wakeup_pkg::wake_reset;
      q.wdt_field <= `WDT_FIELD_OFF;
      q.ws <= `WDT_PERIOD_RESET;
      q.pa_wake_en <= `PORT_A_WAKE_RESET;
      q.power_down_flag <= 1'b0;
      q.high_speed_internal_rc_run <= 1'b1;
      q.clr_s1 <= 1'b1;
      q.clr_s2 <= 1'b1;
      q.pa_s1 <= 8'hff;
      q.pa_s2 <= 8'hff;
      q.pa_prev <= 8'hff;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs, all straight from flip-flops
  // ****************************************
  assign dat_o = q.rdata;
  assign ack_o = q.ack;
  assign cpu_run = q.cpu_run;
  assign high_speed_internal_rc_run = q.high_speed_internal_rc_run;
  assign slow_mode = q.slow_mode;
  assign port_hold = q.port_hold;
  assign sys_reset = q.sys_reset;
  assign pc_sp_reset = q.pc_sp_reset;
  assign irq_service = q.irq_service;
  assign resume_next = q.resume_next;

endmodule : sleep_wakeup_and_watchdog

`default_nettype wire

// *** sleep_wakeup_defines.svh ***
// Constants for the sleep, wake-up and watchdog block: offsets, fields, reset values, timings.
// Assumes a 125 MHz system clock and a Wishbone bus with 32-bit data and byte addresses.
`ifndef SLEEP_WAKEUP_DEFINES_SVH
`define SLEEP_WAKEUP_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_SYSTEM_CONTROL_A 8'h00
`define OFS_SYSTEM_CONTROL_B 8'h04
`define OFS_WDT_PERIOD_SEL 8'h08
`define OFS_STATUS 8'h0c
`define OFS_PORT_A_WAKE_EN 8'h10

// ****************************************
// Field positions
// ****************************************
`define BIT_CLOCK_SPEED_SELECT 0
`define BIT_CRYSTAL_LOW_POWER 1
`define BIT_POWER_DOWN_FLAG 0
`define BIT_WDT_EXPIRED_FLAG 1
`define BIT_SLEEPING 2
`define BIT_WDT_RUNNING 3
`define BIT_SLOW_MODE 4

// ****************************************
// Reset values and codes
// ****************************************
`define WDT_FIELD_OFF 4'ha
`define WDT_FIELD_RECOMMENDED_ON 4'h5
`define WDT_PERIOD_RESET 3'h7
`define PORT_A_WAKE_RESET 8'h00

// ****************************************
// Timing
// ****************************************
`define CLK_FREQ_MHZ 125
`define RESET_DELAY_US 100000
`define SST_SHORT_CYCLES 24'h000002
`define SST_LONG_CYCLES 24'h000400

`endif

// *** sleep_wakeup_pkg.sv ***
// Types for the sleep, wake-up and watchdog block.
// Assumes the constants header is included by the design file that uses these types.
`default_nettype none

package sleep_wakeup_pkg;

  // ****************************************
  // Enumerations
  // ****************************************
  // Controller state
  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_sleep = 2'b01,
    st_rst_delay = 2'b10,
    st_startup = 2'b11
  } mode_e;

  // Oscillator configuration option
  typedef enum logic [1:0] {
    osc_hxt = 2'b00,
    osc_erc = 2'b01,
    osc_high_speed_internal_rc = 2'b10,
    osc_high_speed_internal_rc_lxt = 2'b11
  } osc_e;

  // Watchdog clock source option
  typedef enum logic [1:0] {
    wsrc_lxt = 2'b00,
    wsrc_sys_div4 = 2'b01,
    wsrc_low_speed_internal_rc = 2'b10
  } wdt_src_e;

  // Reason for the current start-up
  typedef enum logic [1:0] {
    wake_port = 2'b00,
    wake_irq = 2'b01,
    wake_wdt_sleep = 2'b10,
    wake_reset = 2'b11
  } wake_e;

  // ****************************************
  // Carriers
  // ****************************************
  // One-cycle instruction strobes from the CPU core
  typedef struct packed {
    logic sleep_insn;
    logic clear_insn;
    logic clear_first;
    logic clear_second;
  } cpu_cmd_s;

  // Configuration options, static after power-up
  typedef struct packed {
    logic wdt_force_on;
    logic clear_pair_mode;
    wdt_src_e wdt_src;
    osc_e osc_type;
    logic sst_short;
  } cfg_s;

  // Whole block state
  typedef struct packed {
    mode_e st;
    wake_e src;
    logic ack;
    logic [31:0] rdata;
    logic clk_sel;
    logic lxt_lp;
    logic [3:0] wdt_field;
    logic [2:0] ws;
    logic [7:0] pa_wake_en;
    logic power_down_flag;
    logic to;
    logic [14:0] wdt_cnt;
    logic [1:0] div;
    logic half_first;
    logic half_second;
    logic [3:0] irq_old;
    logic [7:0] pa_s1;
    logic [7:0] pa_s2;
    logic [7:0] pa_prev;
    logic clr_s1;
    logic clr_s2;
    logic lxt_s1;
    logic lxt_s2;
    logic lxt_prev;
    logic low_speed_internal_rc_s1;
    logic low_speed_internal_rc_s2;
    logic low_speed_internal_rc_prev;
    logic [23:0] dly;
    logic cpu_run;
    logic high_speed_internal_rc_run;
    logic slow_mode;
    logic port_hold;
    logic sys_reset;
    logic pc_sp_reset;
    logic irq_service;
    logic resume_next;
  } state_s;

endpackage : sleep_wakeup_pkg

`default_nettype wire

// *** sleep_wakeup_and_watchdog_asserts.sv ***
// Checker for the sleep, wake-up and watchdog block.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module sleep_wakeup_and_watchdog_asserts (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  input wire sleep_wakeup_pkg::cpu_cmd_s cpu_cmd,
  input wire sleep_wakeup_pkg::cfg_s cfg,
  input wire logic cpu_run,
  input wire logic high_speed_internal_rc_run,
  input wire logic slow_mode,
  input wire logic port_hold,
  input wire logic sys_reset,
  input wire logic pc_sp_reset,
  input wire logic irq_service,
  input wire logic resume_next
);
  // One clock domain, so one default clocking and disable
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // ****************************************
  // Bus and sleep properties
  // ****************************************
  property p_ack_once; ack_o |=> !ack_o; endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack stood two cycles");
  property p_dat_idle; !ack_o |-> dat_o == 32'h00000000; endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data not zero outside ack");
  property p_sleep_entry; cpu_run && cpu_cmd.sleep_insn |=> port_hold && !cpu_run && !high_speed_internal_rc_run; endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("halt did not enter sleep");
  // Ports stay held through start-up too, while the fast oscillator already runs unless in slow mode
  property p_sleep_hold;
    port_hold |-> !cpu_run && !resume_next && !irq_service && !sys_reset && !pc_sp_reset;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("activity while asleep");
  // Only one kind of restart may end a start-up
  property p_one_cause; $onehot0({sys_reset, pc_sp_reset, irq_service, resume_next}); endproperty
  a_one_cause: assert property (p_one_cause)
    else $error("two restart kinds at once");
  property p_slow; slow_mode |-> cfg.osc_type == sleep_wakeup_pkg::osc_high_speed_internal_rc_lxt; endproperty
  a_slow: assert property (p_slow)
    else $error("slow mode outside dual oscillator setup");
  property p_resume; resume_next || irq_service |-> ##[0:1] cpu_run; endproperty
  a_resume: assert property (p_resume)
    else $error("program did not resume");
  // Start-up is at least two clocks with the program held
  property p_startup; resume_next || irq_service || pc_sp_reset |-> !$past(cpu_run, 2); endproperty
  a_startup: assert property (p_startup)
    else $error("restart without start-up wait");

  // Main scenarios
  c_sleep: cover property (cpu_run && cpu_cmd.sleep_insn);
  c_irq: cover property (irq_service);
  c_pc_sp: cover property (pc_sp_reset);
endmodule : sleep_wakeup_and_watchdog_asserts

bind sleep_wakeup_and_watchdog sleep_wakeup_and_watchdog_asserts u_sleep_wakeup_and_watchdog_asserts (
  .sys_clk, .reset, .ack_o, .dat_o, .cpu_cmd, .cfg, .cpu_run, .high_speed_internal_rc_run, .slow_mode,
  .port_hold, .sys_reset, .pc_sp_reset, .irq_service, .resume_next);

`default_nettype wire

// *** cpu_core_model.sv ***
// Model of the CPU core that issues halt and clear strobes.
// Assumes the bench calls issue() just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model (
  input wire logic sys_clk,
  input wire logic cpu_run,
  output var sleep_wakeup_pkg::cpu_cmd_s cpu_cmd
);
  initial cpu_cmd = '0;

  // One strobe, only while the program runs; a gap cycle follows
  // so a second call never assigns the strobe twice in one step
  task automatic issue(input logic [3:0] k);
    int n;
    n = 0;
    while (cpu_run !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    cpu_cmd <= k;
    @(posedge sys_clk);
    cpu_cmd <= '0;
    @(posedge sys_clk);
  endtask : issue
endmodule : cpu_core_model

`default_nettype wire

// *** sleep_wakeup_and_watchdog_test.sv ***
// Self-checking bench for the sleep, wake-up and watchdog block.
// Assumes a shortened reset delay of 20 cycles and 2-cycle start-up.
`include "sleep_wakeup_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sleep_wakeup_and_watchdog_test;
  logic sys_clk = 1'b0, reset = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00, port_a_pins = 8'hff;
  logic [3:0] sel_i = 4'h0, irq_request = 4'h0, irq_enable = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic stack_full = 1'b0, external_clear_pin_n = 1'b1, low_speed_internal_rc_clk = 1'b0, lxt_clk = 1'b0;
  logic ack_o, cpu_run, high_speed_internal_rc_run, slow_mode, port_hold, sys_reset, pc_sp_reset, irq_service, resume_next;
  sleep_wakeup_pkg::cpu_cmd_s cpu_cmd;
  sleep_wakeup_pkg::cfg_s cfg = '{1'b0, 1'b0, sleep_wakeup_pkg::wsrc_sys_div4, sleep_wakeup_pkg::osc_high_speed_internal_rc, 1'b1};
  wire logic [3:0] pulses = {sys_reset, pc_sp_reset, irq_service, resume_next};
  int errors = 0, num_checks = 0, last_wait;

  always #4 sys_clk = ~sys_clk;
  // Internal slow RC runs free, one tick per 16 clocks
  always begin
    repeat (8) @(posedge sys_clk);
    low_speed_internal_rc_clk <= ~low_speed_internal_rc_clk;
  end
  // Crystal runs free as well, one tick per 8 clocks
  always begin
    repeat (4) @(posedge sys_clk);
    lxt_clk <= ~lxt_clk;
  end

  sleep_wakeup_and_watchdog #(.RESET_DELAY_CYCLES(20)) u_sleep_wakeup_and_watchdog (
    .sys_clk, .reset, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .cpu_cmd, .cfg,
    .irq_request, .irq_enable, .stack_full, .port_a_pins, .external_clear_pin_n, .lxt_clk,
    .low_speed_internal_rc_clk, .cpu_run, .high_speed_internal_rc_run, .slow_mode, .port_hold, .sys_reset, .pc_sp_reset, .irq_service,
    .resume_next);
  cpu_core_model u_cpu_core_model (.sys_clk, .cpu_run, .cpu_cmd);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    if (errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // Classic cycle: hold until ack is sampled, then release a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                    input logic [3:0] s = 4'hf);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack_o !== 1'b1 && n < 100);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge sys_clk);
    if (n >= 100) check("bus ack", 1'b0, 1'b1);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic [31:0] q;
    wb(1'b1, a, d, q, s);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what, input logic [31:0] m = '1);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(what, q & m, e);
  endtask : rd

  // Bounded wait for a restart pulse, then name which one came
  task automatic wait_pulse(input int idx, input int max);
    last_wait = 0;
    while (pulses === 4'h0 && last_wait < max) begin
      @(posedge sys_clk);
      last_wait++;
    end
    check("restart kind", pulses, 4'h1 << idx);
  endtask : wait_pulse

  task automatic do_reset;
    reset <= 1'b1;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    wait_pulse(3, 1200);
  endtask : do_reset

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power_up;
    rd(`OFS_SYSTEM_CONTROL_B, `WDT_FIELD_OFF, "wdt field");
    rd(`OFS_WDT_PERIOD_SEL, `WDT_PERIOD_RESET, "period");
    rd(`OFS_PORT_A_WAKE_EN, `PORT_A_WAKE_RESET, "wake enable");
    rd(`OFS_STATUS, 32'h0, "status");
    rd(8'h20, 32'h0, "unmapped");
    wr(`OFS_SYSTEM_CONTROL_A, 32'h1);
    rd(`OFS_SYSTEM_CONTROL_A, 32'h1, "control a");
    check("slow mode", slow_mode, 1'b0);
    wr(`OFS_SYSTEM_CONTROL_A, 32'h0);
  endtask : t_power_up

  task automatic t_port_wake;
    wr(`OFS_PORT_A_WAKE_EN, 32'h1);
    u_cpu_core_model.issue(4'h8);
    check("hold", port_hold, 1'b1);
    check("osc stopped", high_speed_internal_rc_run, 1'b0);
    rd(`OFS_STATUS, 32'h5, "asleep");
    port_a_pins <= 8'hfd; // Unenabled pin falls first
    repeat (20) @(posedge sys_clk);
    check("masked pin", port_hold, 1'b1);
    port_a_pins <= 8'hfc;
    wait_pulse(0, 50);
    port_a_pins <= 8'hff;
    u_cpu_core_model.issue(4'h4);
    rd(`OFS_STATUS, 32'h1, "clear no-op");
  endtask : t_port_wake

  task automatic t_irq_wake;
    logic [1:0] mode [3] = '{2'b10, 2'b00, 2'b11}; // Enable, stack full
    for (int i = 0; i < 3; i++) begin
      irq_enable <= {3'b000, mode[i][1]};
      stack_full <= mode[i][0];
      irq_request <= 4'h2; // Pending before halt
      u_cpu_core_model.issue(4'h8);
      repeat (20) @(posedge sys_clk);
      check("pending irq", port_hold, 1'b1);
      irq_request <= 4'h3;
      wait_pulse(i == 0 ? 1 : 0, 50);
      irq_request <= 4'h0;
      @(posedge sys_clk);
    end
  endtask : t_irq_wake

  task automatic t_wdt;
    wr(`OFS_SYSTEM_CONTROL_B, `WDT_FIELD_RECOMMENDED_ON);
    wr(`OFS_WDT_PERIOD_SEL, 32'h0);
    u_cpu_core_model.issue(4'h4);
    rd(`OFS_STATUS, 32'h8, "wdt on");
    wait_pulse(3, 1500);
    rd(`OFS_STATUS, 32'h2, "expired", 32'h3);
    u_cpu_core_model.issue(4'h8);
    repeat (1500) @(posedge sys_clk);
    check("frozen wdt", port_hold, 1'b1);
    external_clear_pin_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    external_clear_pin_n <= 1'b1;
    wait_pulse(3, 200);
    check("reset delay", last_wait >= 20, 1'b1);
    rd(`OFS_STATUS, 32'h1, "flags kept", 32'h3);
  endtask : t_wdt

  task automatic t_low_speed_internal_rc_pair;
    cfg.clear_pair_mode <= 1'b1;
    cfg.wdt_src <= sleep_wakeup_pkg::wsrc_low_speed_internal_rc;
    do_reset();
    wr(`OFS_SYSTEM_CONTROL_B, `WDT_FIELD_RECOMMENDED_ON);
    wr(`OFS_WDT_PERIOD_SEL, 32'h0);
    u_cpu_core_model.issue(4'h8);
    wait_pulse(2, 5000);
    rd(`OFS_STATUS, 32'h3, "sleep overflow", 32'h3);
    u_cpu_core_model.issue(4'h2);
    u_cpu_core_model.issue(4'h2);
    rd(`OFS_STATUS, 32'h1, "same half", 32'h1);
    u_cpu_core_model.issue(4'h1);
    rd(`OFS_STATUS, 32'h0, "pair", 32'h1);
  endtask : t_low_speed_internal_rc_pair

  // Forced watchdog, long start-ups, slow mode and a masked byte write
  task automatic t_slow_mode;
    cfg <= '{1'b1, 1'b0, sleep_wakeup_pkg::wsrc_lxt, sleep_wakeup_pkg::osc_high_speed_internal_rc_lxt, 1'b0};
    do_reset();
    check("long start-up", last_wait >= 1024, 1'b1);
    rd(`OFS_STATUS, 32'h8, "forced on");
    wr(`OFS_SYSTEM_CONTROL_A, 32'h1, 4'he);
    rd(`OFS_SYSTEM_CONTROL_A, 32'h0, "masked write");
    wr(`OFS_SYSTEM_CONTROL_A, 32'h1);
    check("slow mode on", slow_mode, 1'b1);
    check("fast osc off", high_speed_internal_rc_run, 1'b0);
    rd(`OFS_STATUS, 32'h18, "slow status");
    wr(`OFS_PORT_A_WAKE_EN, 32'h1);
    cfg.sst_short <= 1'b1;
    u_cpu_core_model.issue(4'h8);
    port_a_pins <= 8'hfe;
    wait_pulse(0, 1100);
    check("crystal start-up", last_wait >= 1024, 1'b1);
    check("running", cpu_run, 1'b1);
    port_a_pins <= 8'hff;
  endtask : t_slow_mode

  initial begin
    do_reset();
    t_power_up();
    t_port_wake();
    t_irq_wake();
    t_wdt();
    t_low_speed_internal_rc_pair();
    t_slow_mode();
    finish_test();
  end

  // Hang guard, well beyond the expected run
  initial begin
    repeat (30000) @(posedge sys_clk);
    errors++;
    finish_test();
  end
endmodule : sleep_wakeup_and_watchdog_test

`default_nettype wire
